// file: src/ucpd_ctrl.sv
/*
  charging-port detect control: mode decode, charger autodetect state
  machine, data and power switch control, ahb-lite register slave.
  assumes the analog front end reports attach, device type and line
  release as levels, and mode-select pins come straight from pins.
*/
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
// Functional notes
// - dedicated charging runs the autodetect machine while enable pin and sw_en are high, no sub-mode choices.
// - shorted scheme ties d+ and d- through at most 200 ohms.
// - high-bias scheme drives 2.7 v onto both data lines.
// - 1.2 v scheme shorts lines, pulls to 1.2 v, then goes shorted.
// - autodetect starts in the high-bias scheme.
// - bc1.2 attach: power on, no discharge, brief 1.2 v, then shorted.
// - stay shorted until line released, then return to high bias.
// - device accepting high bias keeps the machine in high bias.
// - client mode keeps power switch off, data switch on.
// - data switches closed in cdp, sdp or client mode.
// - data switches enabled only while enable is high.
// - cdp keeps data switches closed, also during handshaking.
// - data switches open when enable low or dedicated charging.
// - current limit does not open the data switches.
// - data switches open while vbus discharge runs.
// - no discharge on 000/001 or 110/111 code changes.
// - codes decode to dcp, sdp, client, cdp as documented.
`timescale 1ns/100ps
`default_nettype none
`include "ucpd_consts.svh"

module ucpd_ctrl #(
  parameter int T_1V2_CYC = `UCPD_T_1V2_CYC,
  parameter int T_DIS_CYC = `UCPD_T_DIS_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins from host system
  input wire logic mode_select_bit1,
  input wire logic mode_select_bit2,
  input wire logic mode_select_bit3,
  input wire logic enable_pin,
  // analog front end
  input wire ucpd_pkg::ucpd_detect_s detect,
  output ucpd_pkg::ucpd_drive_s drive
);
  import ucpd_pkg::*;

  localparam int CW = $clog2(T_DIS_CYC > T_1V2_CYC ? T_DIS_CYC + 1
                                                    : T_1V2_CYC + 1);

  // pin synchronisers
  logic [6:0] sync1;
  logic [6:0] sync2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end else begin
      sync1 <= {mode_select_bit1, mode_select_bit2, mode_select_bit3,
                enable_pin, detect.attach, detect.bc12_type,
                detect.line_release};
      sync2 <= sync1;
    end
  end
  wire logic [2:0] sel = sync2[6:4];
  wire logic en_s = sync2[3];
  wire logic att_s = sync2[2];
  wire logic bc_s = sync2[1];
  wire logic rel_s = sync2[0];

  // software enable register
  logic sw_en;

  // mode decode
  ucpd_mode_e mode;
  always_comb begin
    case (sel[2:1])
      `UCPD_GRP_DCP: mode = UCPD_MODE_DCP;
      `UCPD_GRP_SDP: mode = UCPD_MODE_SDP;
      `UCPD_GRP_CLIENT: mode = UCPD_MODE_CLIENT;
      `UCPD_GRP_HIGH: mode = (sel == `UCPD_SEL_CDP) ? UCPD_MODE_CDP
                                                     : UCPD_MODE_SDP;
      default: mode = UCPD_MODE_DCP;
    endcase
  end

  // discharge on any mode-select code change except the paired codes
  logic [2:0] sel_q;
  logic sel_valid;
  // compare only once the synchronisers hold real pin data
  logic [1:0] fill;
  logic [CW-1:0] dis_cnt;
  logic discharging;
  wire logic pair_lo = (sel_q[2:1] == `UCPD_GRP_DCP) &&
                       (sel[2:1] == `UCPD_GRP_DCP);
  wire logic pair_hi = (sel_q[2:1] == `UCPD_GRP_HIGH) &&
                       (sel[2:1] == `UCPD_GRP_HIGH);
  wire logic sel_chg = sel_valid && (sel != sel_q) &&
                       !pair_lo && !pair_hi;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q <= 3'h0;
      sel_valid <= 1'b0;
      fill <= 2'h0;
    end else begin
      sel_q <= sel;
      fill <= {fill[0], 1'b1};
      sel_valid <= fill[1];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dis_cnt <= '0;
    end else if (sel_chg) begin
      dis_cnt <= CW'(T_DIS_CYC - 1);
    end else if (dis_cnt != '0) begin
      dis_cnt <= dis_cnt - CW'(1);
    end
  end
  assign discharging = (dis_cnt != '0);
  // discharge shows from the cycle the change is seen
  wire logic dis_now = sel_chg || discharging;

  // charger autodetect state machine
  ucpd_scheme_e scheme;
  ucpd_scheme_e next_scheme;
  logic [CW-1:0] t12;
  wire logic dcp_on = (mode == UCPD_MODE_DCP) && en_s && sw_en;
  always_comb begin
    next_scheme = scheme;
    case (scheme)
      UCPD_SCH_OFF: if (dcp_on) begin
        next_scheme = UCPD_SCH_HIGH_BIAS;
      end
      UCPD_SCH_HIGH_BIAS: if (att_s && bc_s) begin
        next_scheme = UCPD_SCH_1V2;
      end // non-bc1.2 attach stays here
      UCPD_SCH_1V2: if (t12 == '0) begin
        next_scheme = UCPD_SCH_SHORTED;
      end
      UCPD_SCH_SHORTED: if (rel_s) begin
        next_scheme = UCPD_SCH_HIGH_BIAS;
      end
      default: next_scheme = UCPD_SCH_OFF;
    endcase
    if (!dcp_on) begin
      next_scheme = UCPD_SCH_OFF;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scheme <= UCPD_SCH_OFF;
    end else begin
      scheme <= next_scheme;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t12 <= '0;
    end else if (scheme != UCPD_SCH_1V2) begin
      t12 <= CW'(T_1V2_CYC - 1);
    end else if (t12 != '0) begin
      t12 <= t12 - CW'(1);
    end
  end

  // analog drive outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive <= '0;
    end else begin
      drive.bias_2v7 <= (next_scheme == UCPD_SCH_HIGH_BIAS);
      drive.bias_1v2 <= (next_scheme == UCPD_SCH_1V2);
      drive.short_lines <= (next_scheme == UCPD_SCH_1V2) ||
                           (next_scheme == UCPD_SCH_SHORTED);
      // power stays on through the autodetect moves
      drive.power_switch <= en_s && sw_en && !dis_now &&
                            (mode != UCPD_MODE_CLIENT);
      drive.discharge <= dis_now;
      // current limit is not an input here
      drive.data_switch <= en_s && sw_en && !dis_now &&
                           (mode != UCPD_MODE_DCP);
    end
  end

  // ahb-lite slave, zero wait states
  logic ph_valid;
  logic ph_write;
  logic [11:0] ph_addr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 12'h000;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr <= haddr;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_en <= 1'b1;
    end else if (ph_valid && ph_write &&
                 ph_addr == `UCPD_ADDR_CTRL) begin
      sw_en <= hwdata[`UCPD_CTRL_EN];
    end
  end
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hsel && htrans[1] && !hwrite) begin
      case (haddr)
        `UCPD_ADDR_CTRL: begin
          next_rdata[2:0] = sel;
          next_rdata[`UCPD_CTRL_EN] = sw_en;
        end
        `UCPD_ADDR_STAT: begin
          next_rdata[`UCPD_ST_SCHEME_LSB +: 2] = scheme;
          next_rdata[`UCPD_ST_DATA_SW] = drive.data_switch;
          next_rdata[`UCPD_ST_PWR_SW] = drive.power_switch;
          next_rdata[`UCPD_ST_DIS] = drive.discharge;
          next_rdata[`UCPD_ST_SHORT] = drive.short_lines;
          next_rdata[`UCPD_ST_BIAS27] = drive.bias_2v7;
          next_rdata[`UCPD_ST_BIAS12] = drive.bias_1v2;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (hready) begin
        hrdata <= next_rdata;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // assertions
  property p_data_off_dcp;
    @(posedge hclk) disable iff (!hresetn)
      (mode == UCPD_MODE_DCP) |=> !drive.data_switch;
  endproperty
  a_data_off_dcp: assert property (p_data_off_dcp)
    else $error("data switch closed in dedicated charging");

  property p_data_on_modes;
    @(posedge hclk) disable iff (!hresetn)
      (en_s && sw_en && !dis_now && mode != UCPD_MODE_DCP)
      |=> drive.data_switch;
  endproperty
  a_data_on_modes: assert property (p_data_on_modes)
    else $error("data switch open in data mode");

  property p_data_en;
    @(posedge hclk) disable iff (!hresetn)
      !en_s |=> !drive.data_switch;
  endproperty
  a_data_en: assert property (p_data_en)
    else $error("data switch closed with enable low");

  property p_dis_data;
    @(posedge hclk) disable iff (!hresetn)
      drive.discharge |-> !drive.data_switch && !drive.power_switch;
  endproperty
  a_dis_data: assert property (p_dis_data)
    else $error("switch closed during discharge");

  property p_client_pwr;
    @(posedge hclk) disable iff (!hresetn)
      (mode == UCPD_MODE_CLIENT) |=> !drive.power_switch;
  endproperty
  a_client_pwr: assert property (p_client_pwr)
    else $error("power on in client mode");

  property p_no_dis_pair;
    @(posedge hclk) disable iff (!hresetn)
      (sel_valid && sel_q == `UCPD_SEL_DCP_LO && sel == `UCPD_SEL_DCP_HI
       && !discharging) |=> !discharging;
  endproperty
  a_no_dis_pair: assert property (p_no_dis_pair)
    else $error("discharge on paired code change");

  property p_start_bias;
    @(posedge hclk) disable iff (!hresetn)
      (scheme == UCPD_SCH_OFF && dcp_on) |=> scheme == UCPD_SCH_HIGH_BIAS;
  endproperty
  a_start_bias: assert property (p_start_bias)
    else $error("autodetect did not start in high bias");

  property p_1v2_then_short;
    @(posedge hclk) disable iff (!hresetn)
      (scheme == UCPD_SCH_1V2 && t12 == '0 && dcp_on)
      |=> scheme == UCPD_SCH_SHORTED;
  endproperty
  a_1v2_then_short: assert property (p_1v2_then_short)
    else $error("1.2 v scheme did not end in shorted");

  property p_short_release;
    @(posedge hclk) disable iff (!hresetn)
      (scheme == UCPD_SCH_SHORTED && rel_s && dcp_on)
      |=> scheme == UCPD_SCH_HIGH_BIAS;
  endproperty
  a_short_release: assert property (p_short_release)
    else $error("shorted scheme did not return on release");

  property p_bias_stay;
    @(posedge hclk) disable iff (!hresetn)
      (scheme == UCPD_SCH_HIGH_BIAS && !bc_s && dcp_on)
      |=> scheme == UCPD_SCH_HIGH_BIAS;
  endproperty
  a_bias_stay: assert property (p_bias_stay)
    else $error("high bias left without bc1.2 device");

  property p_no_dis_pair_hi;
    @(posedge hclk) disable iff (!hresetn)
      (sel_valid && sel_q == `UCPD_SEL_SDP1 && sel == `UCPD_SEL_CDP
       && !discharging) |=> !discharging;
  endproperty
  a_no_dis_pair_hi: assert property (p_no_dis_pair_hi)
    else $error("discharge on paired high code change");

  property p_dis_start;
    @(posedge hclk) disable iff (!hresetn)
      sel_chg |=> drive.discharge && !drive.data_switch;
  endproperty
  a_dis_start: assert property (p_dis_start)
    else $error("no discharge after mode change");
endmodule

`default_nettype wire

// file: src/ucpd_consts.svh
/*
  timing and encoding constants for the charging-port detect control.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef UCPD_CONSTS_SVH
`define UCPD_CONSTS_SVH

// mode-select codes (bit1, bit2, bit3)
`define UCPD_SEL_DCP_LO 3'h0
`define UCPD_SEL_DCP_HI 3'h1
`define UCPD_SEL_SDP1 3'h6
`define UCPD_SEL_CDP 3'h7
// high two bits of the code
`define UCPD_GRP_DCP 2'h0
`define UCPD_GRP_SDP 2'h1
`define UCPD_GRP_CLIENT 2'h2
`define UCPD_GRP_HIGH 2'h3

// 1.2 v scheme interval in microseconds, clock period in ns
`define UCPD_T_1V2_US 100
`define UCPD_CLK_NS 8
`define UCPD_T_1V2_CYC ((`UCPD_T_1V2_US * 1000) / `UCPD_CLK_NS)
// output discharge time in microseconds
`define UCPD_T_DIS_US 200
`define UCPD_T_DIS_CYC ((`UCPD_T_DIS_US * 1000) / `UCPD_CLK_NS)

// register map (byte addresses)
`define UCPD_ADDR_CTRL 12'h000
`define UCPD_ADDR_STAT 12'h004
// control fields
`define UCPD_CTRL_EN 3
// status field positions
`define UCPD_ST_SCHEME_LSB 0
`define UCPD_ST_DATA_SW 4
`define UCPD_ST_PWR_SW 5
`define UCPD_ST_DIS 6
`define UCPD_ST_SHORT 7
`define UCPD_ST_BIAS27 8
`define UCPD_ST_BIAS12 9

`endif

// file: src/ucpd_pkg.sv
/*
  types for the charging-port detect control.
  assumes ucpd_consts.svh is on the include path.
*/
package ucpd_pkg;
  `include "ucpd_consts.svh"

  typedef enum logic [1:0] {
    UCPD_MODE_DCP,
    UCPD_MODE_SDP,
    UCPD_MODE_CLIENT,
    UCPD_MODE_CDP
  } ucpd_mode_e;

  // charger autodetect scheme
  typedef enum logic [1:0] {
    UCPD_SCH_OFF,
    UCPD_SCH_HIGH_BIAS,
    UCPD_SCH_1V2,
    UCPD_SCH_SHORTED
  } ucpd_scheme_e;

  // digital indications from the analog detection front end
  typedef struct packed {
    logic attach;
    logic bc12_type;
    logic line_release;
  } ucpd_detect_s;

  // analog control outputs
  typedef struct packed {
    logic short_lines;
    logic bias_2v7;
    logic bias_1v2;
    logic data_switch;
    logic power_switch;
    logic discharge;
  } ucpd_drive_s;
endpackage

// file: test/ucpd_dev_model.sv
/*
  attached portable device seen through the analog front end.
  assumes the bench commands plug-in and device type per clock.
*/
`timescale 1ns/100ps
`default_nettype none

module ucpd_dev_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench commands
  input wire logic plug,
  input wire logic bc12,
  // front-end levels
  output ucpd_pkg::ucpd_detect_s detect
);
  import ucpd_pkg::*;

  // lines released whenever unplugged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      detect <= ucpd_detect_s'(3'h1);
    end else begin
      detect.attach <= plug;
      detect.bc12_type <= plug & bc12;
      detect.line_release <= !plug;
    end
  end
endmodule
`default_nettype wire

// file: test/ucpd_ctrl_tb_top.sv
/*
  self-checking bench for the charging-port detect control.
  assumes ucpd_pkg and the device model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module ucpd_ctrl_tb_top;
  import ucpd_pkg::*;

  logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, code;
  logic [31:0] hwdata, hrdata, rd;
  logic enable_pin, plug, bc12;
  ucpd_detect_s detect;
  ucpd_drive_s drive;
  int err_count, tests_run;

  assign hready = hreadyout;

  ucpd_ctrl #(.T_1V2_CYC(8), .T_DIS_CYC(16)) u_ucpd_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mode_select_bit1(code[2]),
    .mode_select_bit2(code[1]), .mode_select_bit3(code[0]),
    .enable_pin(enable_pin), .detect(detect), .drive(drive)
  );

  ucpd_dev_model u_ucpd_dev_model (
    .hclk(hclk), .hresetn(hresetn), .plug(plug), .bc12(bc12),
    .detect(detect)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // single word transfer, waits on hready in both phases
  task automatic ahb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  // drive state after n settled cycles
  task automatic look(input int n, input logic [5:0] exp);
    repeat (n) @(posedge hclk);
    #1 chk({26'h0, drive}, {26'h0, exp});
  endtask

  task automatic setm(input logic [2:0] c);
    @(posedge hclk);
    code <= c;
  endtask

  initial begin
    {hsel, hwrite, haddr, htrans, hwdata, plug, bc12} = '0;
    hsize = 3'h2;
    code = 3'h0;
    enable_pin = 1'b1;
    hresetn = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 12'h000, 32'h0, rd);
    chk(rd, 32'h8);
    ahb(1'b0, 12'h010, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, 12'h000, 32'h0, rd);
    ahb(1'b0, 12'h000, 32'h0, rd);
    chk(rd, 32'h0);
    look(5, 6'h00);
    ahb(1'b1, 12'h000, 32'h8, rd);
    chk({31'h0, hresp}, 32'h0);
    $display("test registers done");
    look(5, 6'h12);
    ahb(1'b0, 12'h004, 32'h0, rd);
    chk(rd, 32'h121);
    setm(3'h1);
    look(5, 6'h12);
    plug <= 1'b1;
    bc12 <= 1'b1;
    look(5, 6'h2a);
    look(12, 6'h22);
    look(20, 6'h22);
    plug <= 1'b0;
    bc12 <= 1'b0;
    look(5, 6'h12);
    plug <= 1'b1;
    look(25, 6'h12);
    plug <= 1'b0;
    $display("test autodetect done");
    setm(3'h3);
    look(5, 6'h01);
    look(20, 6'h06);
    setm(3'h5);
    look(5, 6'h01);
    look(20, 6'h04);
    setm(3'h6);
    look(25, 6'h06);
    setm(3'h7);
    look(5, 6'h06);
    @(posedge hclk);
    enable_pin <= 1'b0;
    look(5, 6'h00);
    @(posedge hclk);
    enable_pin <= 1'b1;
    look(5, 6'h06);
    setm(3'h0);
    look(25, 6'h12);
    $display("test switches done");
    ahb(1'b1, 12'h000, 32'h0, rd);
    @(posedge hclk);
    hresetn <= 1'b0;
    look(2, 6'h00);
    @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 12'h000, 32'h0, rd);
    chk(rd, 32'h8);
    look(5, 6'h12);
    $display("test reset done");
    test_done();
  end

  // hang guard, about twenty times the expected run length
  initial begin
    #40000;
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
